// >>> src/drd_engine.v
// Descriptor ring DMA engine: pointers, descriptor fetch, data move and status write-back
`default_nettype none
`include "drd_map.vh"

module drd_engine #(
  parameter AW = 8
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        ce,
  input  wire [AW-1:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  output wire [31:0] mem_addr,
  output wire        mem_rd,
  output wire        mem_wr,
  output wire [31:0] mem_wdata,
  input  wire [31:0] mem_rdata,
  output wire        txs_valid,
  output wire [31:0] txs_data,
  output wire        txs_first,
  output wire        txs_last,
  output wire [3:0]  txs_user,
  input  wire        txs_ready,
  input  wire        rxs_valid,
  input  wire [31:0] rxs_data,
  input  wire        rxs_last,
  output wire        rxs_ready,
  output wire        pkt_done_pulse,
  output wire        group_irq_pulse
);

  // ============================================================
  // Registers
  reg  [31:0] ctrl_reg;
  reg  [31:0] base_reg;
  reg  [31:0] last_reg;
  reg  [31:0] software_submit_pointer;
  reg  [31:0] engine_fetch_pointer;
  reg  [31:0] engine_done_pointer;
  reg  [31:0] count_reg;
  reg  [31:0] rdata_reg;
  reg  [2:0]  state_reg;
  reg  [31:0] buf_reg;
  reg  [31:0] ctl_reg;
  reg  [15:0] cnt_reg;
  reg  [15:0] pkt_len_reg;
  reg  [15:0] pkt_words_reg;
  reg         rd_pend_reg;
  reg         in_pkt_reg;
  reg         first_reg;
  reg         end_reg;
  reg  [7:0]  grp_cnt_reg;
  reg  [31:0] mem_addr_reg;
  reg         mem_rd_reg;
  reg         mem_wr_reg;
  reg  [31:0] mem_wdata_reg;
  reg         txv_reg;
  reg  [31:0] txd_reg;
  reg         txf_reg;
  reg         txl_reg;
  reg         rxr_reg;
  reg         pkt_reg;
  reg         grp_reg;

  wire        enable = ctrl_reg[`DRD_CTRL_EN];
  wire        dir_rx = ctrl_reg[`DRD_CTRL_DIR];
  wire [7:0]  grp_n  = ctrl_reg[`DRD_CTRL_GRP_HI:`DRD_CTRL_GRP_LO];
  wire [15:0] len    = ctl_reg[`DRD_LEN_HI:`DRD_LEN_LO];
  wire [15:0] cnt_p1 = cnt_reg + 16'h0001;
  wire        busy   = (state_reg != `DRD_ST_IDLE);
  wire        rx_acc = rxs_valid & rxr_reg;

  // Byte address of the current buffer word
  wire [31:0] buf_slot = buf_reg + {14'h0000, cnt_reg, 2'b00};

  // Status word written back; rx packs first/last of the packet, tx echoes request
  wire        s_first = dir_rx ? first_reg : ctl_reg[`DRD_D_FIRST];
  wire        s_last  = dir_rx ? end_reg : ctl_reg[`DRD_D_LAST];
  wire [31:0] status_word = {1'b1, s_first, s_last, 1'b0,
                             ctl_reg[`DRD_D_USER_HI:`DRD_D_USER_LO],
                             8'h00, cnt_reg};

  // Next ring slot, wrapping after the last descriptor
  wire [31:0] fetch_adv = (engine_fetch_pointer == last_reg) ? base_reg
                        : engine_fetch_pointer + `DRD_DESC_STRIDE;

  assign reg_rdata       = rdata_reg;
  assign mem_addr        = mem_addr_reg;
  assign mem_rd          = mem_rd_reg;
  assign mem_wr          = mem_wr_reg;
  assign mem_wdata       = mem_wdata_reg;
  assign txs_valid       = txv_reg;
  assign txs_data        = txd_reg;
  assign txs_first       = txf_reg;
  assign txs_last        = txl_reg;
  assign txs_user        = ctl_reg[`DRD_D_USER_HI:`DRD_D_USER_LO];
  assign rxs_ready       = rxr_reg;
  assign pkt_done_pulse  = pkt_reg;
  assign group_irq_pulse = grp_reg;

  // ============================================================
  // Register read port: data stands the cycle after the strobe only
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `DRD_CTRL_OFS:   rdata_reg <= ctrl_reg;
          `DRD_BASE_OFS:   rdata_reg <= base_reg;
          `DRD_LAST_OFS:   rdata_reg <= last_reg;
          `DRD_SUBMIT_OFS: rdata_reg <= software_submit_pointer;
          `DRD_FETCH_OFS:  rdata_reg <= engine_fetch_pointer;
          `DRD_DONE_OFS:   rdata_reg <= engine_done_pointer;
          `DRD_STAT_OFS:   rdata_reg <= {pkt_len_reg, 14'h0000, in_pkt_reg, busy};
          `DRD_COUNT_OFS:  rdata_reg <= count_reg;
          default:         rdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ============================================================
  // Software-owned configuration; pointer writes never stall the engine
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg                <= `DRD_CTRL_RST;
      base_reg                <= `DRD_PTR_RST;
      last_reg                <= `DRD_PTR_RST;
      software_submit_pointer <= `DRD_PTR_RST;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `DRD_CTRL_OFS:   ctrl_reg <= reg_wdata;
        `DRD_BASE_OFS:   base_reg <= reg_wdata;
        `DRD_LAST_OFS:   last_reg <= reg_wdata;
        `DRD_SUBMIT_OFS: software_submit_pointer <= reg_wdata;
        default:         ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ============================================================
  // Descriptor engine: fetch, move, write back, advance
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg            <= `DRD_ST_IDLE;
      engine_fetch_pointer <= `DRD_PTR_RST;
      engine_done_pointer  <= `DRD_PTR_RST;
      count_reg            <= 32'h0000_0000;
      buf_reg              <= 32'h0000_0000;
      ctl_reg              <= 32'h0000_0000;
      cnt_reg              <= 16'h0000;
      pkt_len_reg          <= 16'h0000;
      pkt_words_reg        <= 16'h0000;
      rd_pend_reg          <= 1'b0;
      in_pkt_reg           <= 1'b0;
      first_reg            <= 1'b0;
      end_reg              <= 1'b0;
      grp_cnt_reg          <= 8'h00;
      mem_addr_reg         <= 32'h0000_0000;
      mem_rd_reg           <= 1'b0;
      mem_wr_reg           <= 1'b0;
      mem_wdata_reg        <= 32'h0000_0000;
      txv_reg              <= 1'b0;
      txd_reg              <= 32'h0000_0000;
      txf_reg              <= 1'b0;
      txl_reg              <= 1'b0;
      rxr_reg              <= 1'b0;
      pkt_reg              <= 1'b0;
      grp_reg              <= 1'b0;
    end else if (ce) begin
      // Strobes and notifications last one cycle
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      pkt_reg    <= 1'b0;
      grp_reg    <= 1'b0;
      // A write to the count register clears it, unless a descriptor finishes in that cycle: its increment wins and the count becomes its old value plus one
      if (reg_wr && reg_addr == `DRD_COUNT_OFS) begin
        count_reg <= 32'h0000_0000;
      end
      case (state_reg)
        `DRD_ST_IDLE: begin
          // Work only while submitted descriptors remain
          if (enable && engine_fetch_pointer != software_submit_pointer) begin
            state_reg <= `DRD_ST_RDA;
          end
        end
        `DRD_ST_RDA: begin
          mem_rd_reg   <= 1'b1;
          mem_addr_reg <= engine_fetch_pointer;
          state_reg    <= `DRD_ST_RDC;
        end
        `DRD_ST_RDC: begin
          buf_reg      <= mem_rdata;
          mem_rd_reg   <= 1'b1;
          mem_addr_reg <= engine_fetch_pointer + `DRD_CTL_OFS;
          state_reg    <= `DRD_ST_CAP;
        end
        `DRD_ST_CAP: begin
          ctl_reg     <= mem_rdata;
          cnt_reg     <= 16'h0000;
          rd_pend_reg <= 1'b0;
          end_reg     <= 1'b0;
          // A packet starts in the first descriptor after the previous one ended
          first_reg   <= ~in_pkt_reg;
          state_reg   <= `DRD_ST_MOVE;
        end
        `DRD_ST_MOVE: begin
          if (!dir_rx) begin
            // Transmit: one read in flight, then hold the word until taken
            if (rd_pend_reg) begin
              rd_pend_reg <= 1'b0;
              txv_reg     <= 1'b1;
              txd_reg     <= mem_rdata;
              txf_reg     <= ctl_reg[`DRD_D_FIRST] && cnt_reg == 16'h0000;
              txl_reg     <= ctl_reg[`DRD_D_LAST] && cnt_p1 == len;
              cnt_reg     <= cnt_p1;
            end else if (txv_reg) begin
              if (txs_ready) begin
                txv_reg <= 1'b0;
              end
            end else if (cnt_reg == len) begin
              state_reg <= `DRD_ST_WB;
            end else begin
              mem_rd_reg   <= 1'b1;
              mem_addr_reg <= buf_slot;
              rd_pend_reg  <= 1'b1;
            end
          end else begin
            // Receive: store words until packet end or buffer full
            if (rx_acc) begin
              mem_wr_reg    <= 1'b1;
              mem_addr_reg  <= buf_slot;
              mem_wdata_reg <= rxs_data;
              cnt_reg       <= cnt_p1;
              pkt_words_reg <= pkt_words_reg + 16'h0001;
              in_pkt_reg    <= ~rxs_last;
              if (rxs_last || cnt_p1 == len) begin
                rxr_reg   <= 1'b0;
                end_reg   <= rxs_last;
                state_reg <= `DRD_ST_WB;
              end
              if (rxs_last) begin
                pkt_len_reg   <= pkt_words_reg + 16'h0001;
                pkt_words_reg <= 16'h0000;
              end
            end else if (len == 16'h0000) begin
              state_reg <= `DRD_ST_WB;
            end else begin
              rxr_reg <= 1'b1;
            end
          end
        end
        `DRD_ST_WB: begin
          // Completion, packet flags and word count go back into the descriptor
          mem_wr_reg          <= 1'b1;
          mem_addr_reg        <= engine_fetch_pointer + `DRD_CTL_OFS;
          mem_wdata_reg       <= status_word;
          engine_done_pointer <= engine_fetch_pointer;
          count_reg           <= count_reg + 32'h0000_0001;
          pkt_reg             <= s_last;
          // Group interrupt every N descriptors; N of zero turns it off
          if (grp_n != 8'h00 && grp_cnt_reg + 8'h01 == grp_n) begin
            grp_reg     <= 1'b1;
            grp_cnt_reg <= 8'h00;
          end else if (grp_n != 8'h00) begin
            grp_cnt_reg <= grp_cnt_reg + 8'h01;
          end
          state_reg <= `DRD_ST_ADV;
        end
        `DRD_ST_ADV: begin
          engine_fetch_pointer <= fetch_adv;
          state_reg            <= `DRD_ST_IDLE;
        end
        default: begin
          state_reg <= `DRD_ST_IDLE;
        end
      endcase
      // Software may reposition pointers; placed last so an engine update in the same cycle loses
      if (reg_wr && reg_addr == `DRD_FETCH_OFS) begin
        engine_fetch_pointer <= reg_wdata;
      end
      if (reg_wr && reg_addr == `DRD_DONE_OFS) begin
        engine_done_pointer <= reg_wdata;
      end
    end
  end

endmodule
`default_nettype wire

// >>> src/drd_map.vh
// Register offsets, field positions, reset values and descriptor layout of the ring DMA engine
`ifndef DRD_MAP_VH
`define DRD_MAP_VH

// ============================================================
// Register byte offsets
`define DRD_CTRL_OFS    8'h00
`define DRD_BASE_OFS    8'h04
`define DRD_LAST_OFS    8'h08
`define DRD_SUBMIT_OFS  8'h0c
`define DRD_FETCH_OFS   8'h10
`define DRD_DONE_OFS    8'h14
`define DRD_STAT_OFS    8'h18
`define DRD_COUNT_OFS   8'h1c

// ============================================================
// Control register fields and reset values
`define DRD_CTRL_EN     0
`define DRD_CTRL_DIR    1
`define DRD_CTRL_GRP_HI 15
`define DRD_CTRL_GRP_LO 8
`define DRD_CTRL_RST    32'h0000_0000
`define DRD_PTR_RST     32'h0000_0000

// ============================================================
// Descriptor layout: word 0 buffer address, word 1 control and status
`define DRD_DESC_STRIDE 32'h0000_0008
`define DRD_CTL_OFS     32'h0000_0004
`define DRD_LEN_HI      15
`define DRD_LEN_LO      0
`define DRD_D_FIRST     16
`define DRD_D_LAST      17
`define DRD_D_IRQ       18
`define DRD_D_USER_HI   23
`define DRD_D_USER_LO   20
`define DRD_S_DONE      31
`define DRD_S_FIRST     30
`define DRD_S_LAST      29
`define DRD_S_USER_HI   27
`define DRD_S_USER_LO   24

// ============================================================
// Engine states
`define DRD_ST_IDLE 3'h0
`define DRD_ST_RDA  3'h1
`define DRD_ST_RDC  3'h2
`define DRD_ST_CAP  3'h3
`define DRD_ST_MOVE 3'h4
`define DRD_ST_WB   3'h5
`define DRD_ST_ADV  3'h6

`endif

// >>> dv/drd_host_mem.sv
// Host memory model holding descriptor rings and packet buffers
`default_nettype none
module drd_host_mem (
  input  wire logic        clk_sys,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_wdata,
  output var  logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] words [0:255];  // Rings and buffers
  initial mem_rdata = 32'h0;
  // Writes land on the rising edge that samples the strobe
  always @(posedge clk_sys) begin
    if (mem_wr) words[mem_addr[9:2]] <= mem_wdata;
  end
  // The engine takes read data at the edge that ends its strobe cycle, so answer mid-cycle;
  // a bus not read shows the inverse so stale data never matches
  always @(negedge clk_sys) begin
    if (mem_rd) mem_rdata <= words[mem_addr[9:2]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

// >>> dv/drd_engine_props.sv
// Concurrent checks on the ports of the ring engine
`default_nettype none
module drd_engine_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [31:0] mem_wdata,
  input wire logic        txs_valid,
  input wire logic        txs_ready,
  input wire logic [31:0] txs_data,
  input wire logic        txs_first,
  input wire logic        txs_last,
  input wire logic        rxs_valid,
  input wire logic        rxs_ready,
  input wire logic [31:0] rxs_data,
  input wire logic        rxs_last,
  input wire logic        pkt_done_pulse,
  input wire logic        group_irq_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ============================================================
  // Register port and memory side
  read_idle_a: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  mem_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("memory read and write together");
  fetch_pair_a: assert property (mem_rd ##1 mem_rd |-> mem_addr == $past(mem_addr) + 32'h4 ##1 !mem_rd)
    else $error("descriptor words not fetched as a pair");
  // ============================================================
  // Streams and notification
  tx_hold_a: assert property (txs_valid && !txs_ready |=>
    txs_valid && $stable(txs_data) && $stable(txs_first) && $stable(txs_last))
    else $error("tx word changed while stalled");
  tx_gap_a: assert property (txs_valid && txs_ready |=> !txs_valid)
    else $error("tx valid stayed after handshake");
  rx_store_a: assert property (rxs_valid && rxs_ready |=> mem_wr && mem_wdata == $past(rxs_data))
    else $error("rx word not written next cycle");
  rx_end_a: assert property (rxs_valid && rxs_ready && rxs_last |=> !rxs_ready)
    else $error("rx ready stayed after packet end");
  pkt_pulse_a: assert property (pkt_done_pulse |-> mem_wr && mem_wdata[31] && mem_wdata[29] ##1 !pkt_done_pulse)
    else $error("packet pulse without last status write");
  grp_pulse_a: assert property (group_irq_pulse |=> !group_irq_pulse)
    else $error("group pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> dv/descriptor_ring_dma_test.sv
// Self-checking bench for the descriptor ring engine
`default_nettype none
module descriptor_ring_dma_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} drd_row_t;
  logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rxs_data = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata, txs_data;
  logic        txs_ready = 1'b0, rxs_valid = 1'b0, rxs_last = 1'b0, mem_rd, mem_wr;
  logic        txs_valid, txs_first, txs_last, rxs_ready, pkt_done_pulse, group_irq_pulse;
  logic [3:0]  txs_user;
  logic [37:0] txq [$];
  int          mismatches = 0, compares = 0, npkt = 0, ngrp = 0;
  // Reset values first, then ring set-up with read-only and unmapped places
  drd_row_t rows [13] = '{'{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h0},
    '{8'h14, 1'b0, 32'h0, 32'h0}, '{8'h1c, 1'b0, 32'h0, 32'h0}, '{8'h18, 1'b0, 32'h0, 32'h0},
    '{8'h20, 1'b0, 32'h0, 32'h0}, '{8'h04, 1'b1, 32'h100, 32'h100}, '{8'h08, 1'b1, 32'h110, 32'h110},
    '{8'h0c, 1'b1, 32'h100, 32'h100}, '{8'h10, 1'b1, 32'h100, 32'h100}, '{8'h14, 1'b1, 32'h0, 32'h0},
    '{8'h18, 1'b1, 32'hffff_ffff, 32'h0}, '{8'h20, 1'b1, 32'h1234, 32'h0}};
  logic [37:0] exp_tx [4] = '{{2'b11, 4'h5, 32'ha5a5_0001}, {2'b10, 4'ha, 32'h1111_2222},
    {2'b01, 4'ha, 32'h3333_4444}, {2'b11, 4'h3, 32'h5555_6666}};

  always #12.5 clk_sys = ~clk_sys;

  drd_engine dut (.clk_sys, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .txs_valid, .txs_data, .txs_first,
    .txs_last, .txs_user, .txs_ready, .rxs_valid, .rxs_data, .rxs_last, .rxs_ready,
    .pkt_done_pulse, .group_irq_pulse);
  drd_host_mem mem_i (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  // Collect tx words and pulses; the sink stalls every other cycle
  always @(posedge clk_sys) begin
    if (txs_valid && txs_ready) txq.push_back({txs_first, txs_last, txs_user, txs_data});
    if (pkt_done_pulse) npkt++;
    if (group_irq_pulse) ngrp++;
    txs_ready <= ~txs_ready;
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input string n, input logic [37:0] e, input logic [37:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {6'h0, e}, {6'h0, reg_rdata});
  endtask
  task automatic poke(input logic [31:0] a, input logic [31:0] d);
    mem_i.words[a[9:2]] = d;
  endtask
  task automatic peek(input logic [31:0] a, input logic [31:0] e);
    chk($sformatf("mem %h", a), {6'h0, e}, {6'h0, mem_i.words[a[9:2]]});
  endtask
  // Bounded wait for the packet pulse count
  task automatic wait_pkt(input int n);
    for (int i = 0; i < 400 && npkt < n; i++) @(posedge clk_sys);
    // One more edge so the status write-back has landed in memory before any peek
    @(posedge clk_sys);
    chk("packets", n, npkt);
  endtask
  // Hold the word until the engine samples ready, then scramble the released line
  task automatic rx_word(input logic [31:0] d, input logic l);
    int i;
    @(posedge clk_sys);
    rxs_valid <= 1'b1;
    rxs_data <= d;
    rxs_last <= l;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (!rxs_ready && i < 100);
    rxs_valid <= 1'b0;
    rxs_data <= ~d;
  endtask
  task automatic test_done;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #150000;
    mismatches++;
    test_done;
  end

  // ============================================================
  // Main sequence
  initial begin
    poke(32'h100, 32'h200);
    poke(32'h104, 32'h0057_0001);
    poke(32'h108, 32'h240);
    poke(32'h10c, 32'h00a7_0002);
    poke(32'h110, 32'h280);
    poke(32'h114, 32'h0037_0001);
    poke(32'h200, 32'ha5a5_0001);
    poke(32'h240, 32'h1111_2222);
    poke(32'h244, 32'h3333_4444);
    poke(32'h280, 32'h5555_6666);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // A write while the clock enable is low must leave the ring set-up untouched
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(8'h04, 32'h0000_0bad);
    ce <= 1'b1;
    rd(8'h04, 32'h100);
    wr(8'h00, 32'h0000_0201);
    wr(8'h0c, 32'h110);
    wait_pkt(2);
    chk("group", 1, ngrp);
    rd(8'h10, 32'h110);
    rd(8'h14, 32'h108);
    peek(32'h104, 32'he500_0001);
    peek(32'h10c, 32'hea00_0002);
    rd(8'h1c, 32'h2);
    wr(8'h0c, 32'h100);
    wait_pkt(3);
    rd(8'h10, 32'h100);
    rd(8'h14, 32'h110);
    peek(32'h114, 32'he300_0001);
    rd(8'h18, 32'h0);
    chk("tx count", 4, txq.size());
    if (txq.size() == 4) for (int i = 0; i < 4; i++) chk("tx word", exp_tx[i], txq.pop_front());
    poke(32'h100, 32'h300);
    poke(32'h104, 32'h0000_0004);
    wr(8'h00, 32'h0000_0003);
    wr(8'h0c, 32'h108);
    rx_word(32'hc0de_0001, 1'b0);
    rx_word(32'hc0de_0002, 1'b1);
    wait_pkt(4);
    peek(32'h300, 32'hc0de_0001);
    peek(32'h304, 32'hc0de_0002);
    peek(32'h104, 32'he000_0002);
    rd(8'h18, 32'h0002_0000);
    rd(8'h10, 32'h108);
    chk("group off", 1, ngrp);
    test_done;
  end
endmodule

bind drd_engine drd_engine_props u_props (.clk_sys, .rstn, .ce, .reg_rd, .reg_rdata, .mem_addr, .mem_rd,
  .mem_wr, .mem_wdata, .txs_valid, .txs_ready, .txs_data, .txs_first, .txs_last, .rxs_valid, .rxs_ready,
  .rxs_data, .rxs_last, .pkt_done_pulse, .group_irq_pulse);
`default_nettype wire
